// File: core/fumh_pkg.sv
// constants, states and register map of the firmware update message handler
package fumh_pkg;
  // message header byte: type, version, reserved
  localparam int        HDR_TYPE_MSB   = 7;
  localparam int        HDR_TYPE_LSB   = 4;
  localparam int        HDR_VER_MSB    = 3;
  localparam int        HDR_VER_LSB    = 2;
  localparam logic [1:0] PROTO_VERSION = 2'h0;
  localparam logic [1:0] HDR_RESERVED  = 2'h0;
  // message type codes
  localparam logic [3:0] TYPE_OPEN     = 4'h0;
  localparam logic [3:0] TYPE_EXECUTE  = 4'h1;
  localparam logic [3:0] TYPE_CONFIRM  = 4'h2;
  localparam logic [3:0] TYPE_QUERY    = 4'h3;
  localparam logic [3:0] TYPE_ABORT    = 4'h4;
  localparam logic [3:0] TYPE_REPORT   = 4'h5;
  // upgrade states as reported
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_RECEIVING = 4'b0001,
    ST_COMPLETE  = 4'b0010,
    ST_COUNTDOWN = 4'b0011,
    ST_UPGRADE   = 4'b0100,
    ST_EXCEPTION = 4'b0101
  } fumh_state_t;
  // exception code layout and causes
  localparam int        EXC_PERM_BIT   = 15;
  localparam int        EXC_CAUSE_MSB  = 14;
  localparam int        EXC_CAUSE_LSB  = 8;
  localparam logic [6:0] CAUSE_GENERAL  = 7'h00;
  localparam logic [6:0] CAUSE_PROTOCOL = 7'h01;
  localparam logic [6:0] CAUSE_CRC      = 7'h02;
  localparam logic [6:0] CAUSE_IMAGE    = 7'h03;
  localparam logic [6:0] CAUSE_SIGN     = 7'h04;
  localparam logic [6:0] CAUSE_TRIAL    = 7'h05;
  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_SETSTATE  = 8'h08;
  localparam logic [7:0] REG_PAGES     = 8'h0C;
  localparam logic [7:0] REG_EXCCODE   = 8'h10;
  localparam logic [7:0] REG_IRQSTAT   = 8'h14;
  localparam logic [7:0] REG_IRQMASK   = 8'h18;
  localparam logic [7:0] REG_IMAGECRC  = 8'h1C;
  localparam logic [7:0] REG_TIMERS    = 8'h20;
  // ctrl bits and interrupt events
  localparam int        CTRL_ERASE_BIT = 0;
  localparam int        IRQ_W          = 4;
  localparam int        IRQ_REPORT     = 0;
  localparam int        IRQ_UPGRADE    = 1;
  localparam int        IRQ_TRIAL      = 2;
  localparam int        IRQ_ABORT      = 3;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  // timing
  localparam int        CLK_HZ         = 20_000_000;
  localparam int        TICK_PERIOD_S  = 1;
  localparam int        TICK_CYCLES    = CLK_HZ * TICK_PERIOD_S;
endpackage : fumh_pkg

// File: core/fumh_tick.sv
// one-second tick divider
`timescale 1ns/1ps
module fumh_tick
  import fumh_pkg::*;
#(
  parameter int TICK_CYCLES = fumh_pkg::TICK_CYCLES
)(
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      tick
);
  logic [31:0] count;

  // one pulse every TICK_CYCLES clocks [RULE19]
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end
    else if (count == 32'(TICK_CYCLES - 1))
    begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule : fumh_tick

// File: core/fumh_handler.sv
// firmware update control message handler with apb registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE1: header: 4-bit type, zero version, reserved
// RULE2: execute is type 1, 16-bit restart delay
// RULE3: trial period counts only in upgrade state
// RULE4: execute in complete: countdown or upgrade, report
// RULE5: zero delay upgrades now, else countdown first
// RULE6: execute in countdown overwrites both timers
// RULE7: confirm in upgrade drops old image, idle
// RULE8: confirm elsewhere: report only, no action
// RULE9: state query answered with state report
// RULE10: abort goes idle, optional erase, report
// RULE11: report type 5 replies to unicast requests
// RULE12: unexpected requests still get state report
// RULE13: report state nibble plus four zero bits
// RULE14: report echoes crc from session open
// RULE15: page count present only when receiving
// RULE16: exception code present only in exception
// RULE17: exception code: permanence, cause, detail byte
// RULE18: cause codes zero to five, trial expiry five
// RULE19: timers tick per second, reload on execute
module fumh_handler
  import fumh_pkg::*;
#(
  parameter int TICK_CYCLES = fumh_pkg::TICK_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        reqValid,
  input  wire logic        reqUnicast,
  input  wire logic [7:0]  reqHeader,
  input  wire logic [15:0] reqRestartDelay,
  input  wire logic [15:0] reqTrialPeriod,
  input  wire logic [31:0] reqImageCrc,
  output logic             rptValid,
  output logic [7:0]       rptHeader,
  output logic [7:0]       rptState,
  output logic [31:0]      rptCrc,
  output logic             rptHasPages,
  output logic [31:0]      rptPages,
  output logic             rptHasExc,
  output logic [15:0]      rptExcCode,
  output logic             dropOldImage,
  output logic             eraseImage,
  output logic             restartNow,
  output logic             irq
);
  fumh_state_t        state;
  fumh_state_t        next_state;
  logic               tick;
  logic [3:0]         msgType;
  logic               msgOk;
  logic               execTaken;
  logic               trialDone;
  logic               replyPend;
  logic [15:0]        restartCnt;
  logic [15:0]        trialCnt;
  logic [31:0]        imageCrc;
  logic [31:0]        pageCount;
  logic [15:0]        excCode;
  logic [31:0]        ctrl;
  logic [IRQ_W-1:0]   irqStat;
  logic [IRQ_W-1:0]   irqMask;
  logic [IRQ_W-1:0]   irqEvent;
  logic               wrEn;
  logic               cmdSet;

  fumh_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_SETSTATE) ||
             (a == REG_PAGES) || (a == REG_EXCCODE) || (a == REG_IRQSTAT) ||
             (a == REG_IRQMASK) || (a == REG_IMAGECRC) || (a == REG_TIMERS);
  endfunction : mapped

  // header decode, nonzero version is dropped [RULE1]
  assign msgType   = reqHeader[HDR_TYPE_MSB:HDR_TYPE_LSB];
  assign msgOk     = reqValid && (reqHeader[HDR_VER_MSB:HDR_VER_LSB] == PROTO_VERSION);
  // execute acts in complete or countdown only [RULE2] [RULE6]
  assign execTaken = msgOk && (msgType == TYPE_EXECUTE) &&
                     ((state == ST_COMPLETE) || (state == ST_COUNTDOWN));
  assign trialDone = (state == ST_UPGRADE) && (trialCnt == 16'h0000);
  assign wrEn      = psel && penable && pready && pwrite;
  assign cmdSet    = wrEn && (paddr == REG_SETSTATE) && !msgOk;

  // next upgrade state
  always_comb
  begin
    next_state = state;
    if (msgOk)
    begin
      case (msgType)
        TYPE_EXECUTE:
          if (execTaken)
            next_state = (reqRestartDelay == 16'h0000) ? ST_UPGRADE : ST_COUNTDOWN; // [RULE4] [RULE5]
        TYPE_CONFIRM:
          if (state == ST_UPGRADE)
            next_state = ST_IDLE; // [RULE7] [RULE8]
        TYPE_ABORT:
          next_state = ST_IDLE; // [RULE10]
        TYPE_OPEN:
          if (state == ST_IDLE)
            next_state = ST_RECEIVING;
        default:
          next_state = state; // [RULE9] [RULE12]
      endcase
    end
    else if (cmdSet)
    begin
      case (pwdata[3:0])
        ST_RECEIVING: next_state = ST_RECEIVING;
        ST_COMPLETE:  next_state = ST_COMPLETE;
        ST_EXCEPTION: next_state = ST_EXCEPTION;
        default:      next_state = state;
      endcase
    end
    else if ((state == ST_COUNTDOWN) && (restartCnt == 16'h0000))
      next_state = ST_UPGRADE; // [RULE5]
    else if (trialDone)
      next_state = ST_EXCEPTION; // [RULE18]
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // restart and trial timers [RULE19]
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      restartCnt <= 16'h0000;
      trialCnt   <= 16'h0000;
    end
    else if (execTaken)
    begin
      restartCnt <= reqRestartDelay; // [RULE6]
      trialCnt   <= reqTrialPeriod;
    end
    else if (tick)
    begin
      if ((state == ST_COUNTDOWN) && (restartCnt != 16'h0000))
        restartCnt <= restartCnt - 16'h0001;
      if ((state == ST_UPGRADE) && (trialCnt != 16'h0000))
        trialCnt <= trialCnt - 16'h0001; // [RULE3]
    end
  end

  // image crc from session open
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      imageCrc <= 32'h0000_0000;
    else if (msgOk && (msgType == TYPE_OPEN) && (state == ST_IDLE))
      imageCrc <= reqImageCrc; // [RULE14]
  end

  // received page count
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pageCount <= 32'h0000_0000;
    else if (msgOk && (msgType == TYPE_OPEN) && (state == ST_IDLE))
      pageCount <= 32'h0000_0000;
    else if (wrEn && (paddr == REG_PAGES))
      pageCount <= pwdata;
  end

  // exception code, trial expiry sets cause five [RULE17] [RULE18]
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      excCode <= 16'h0000;
    else if (!msgOk && !cmdSet && trialDone)
      excCode <= {1'b0, CAUSE_TRIAL, excCode[7:0]};
    else if (wrEn && (paddr == REG_EXCCODE))
      excCode <= pwdata[15:0];
  end

  // side-effect pulses
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dropOldImage <= 1'b0;
      eraseImage   <= 1'b0;
      restartNow   <= 1'b0;
    end
    else
    begin
      dropOldImage <= (state == ST_UPGRADE) && (next_state == ST_IDLE) &&
                      msgOk && (msgType == TYPE_CONFIRM); // [RULE7]
      eraseImage   <= msgOk && (msgType == TYPE_ABORT) && ctrl[CTRL_ERASE_BIT]; // [RULE10]
      restartNow   <= (next_state == ST_UPGRADE) && (state != ST_UPGRADE);
    end
  end

  // reply one cycle after the state update [RULE11] [RULE12]
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      replyPend <= 1'b0;
    else
      replyPend <= msgOk && reqUnicast && (msgType != TYPE_REPORT);
  end

  // state report
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rptValid    <= 1'b0;
      rptHeader   <= 8'h00;
      rptState    <= 8'h00;
      rptCrc      <= 32'h0000_0000;
      rptHasPages <= 1'b0;
      rptPages    <= 32'h0000_0000;
      rptHasExc   <= 1'b0;
      rptExcCode  <= 16'h0000;
    end
    else
    begin
      rptValid    <= replyPend;
      if (replyPend)
      begin
        rptHeader   <= {TYPE_REPORT, PROTO_VERSION, HDR_RESERVED}; // [RULE11]
        rptState    <= {state, 4'h0}; // [RULE13]
        rptCrc      <= imageCrc; // [RULE14]
        rptHasPages <= (state == ST_RECEIVING); // [RULE15]
        rptPages    <= (state == ST_RECEIVING) ? pageCount : 32'h0000_0000;
        rptHasExc   <= (state == ST_EXCEPTION); // [RULE16]
        rptExcCode  <= (state == ST_EXCEPTION) ? excCode : 16'h0000;
      end
    end
  end

  // control and mask registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl    <= CTRL_RESET;
      irqMask <= '0;
    end
    else if (wrEn && (paddr == REG_CTRL))
      ctrl <= {31'h0000_0000, pwdata[CTRL_ERASE_BIT]};
    else if (wrEn && (paddr == REG_IRQMASK))
      irqMask <= pwdata[IRQ_W-1:0];
  end

  // sticky events, set wins over write-one clear
  assign irqEvent[IRQ_REPORT]  = replyPend;
  assign irqEvent[IRQ_UPGRADE] = (next_state == ST_UPGRADE) && (state != ST_UPGRADE);
  assign irqEvent[IRQ_TRIAL]   = (next_state == ST_EXCEPTION) && trialDone;
  assign irqEvent[IRQ_ABORT]   = msgOk && (msgType == TYPE_ABORT);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irqStat <= '0;
    else if (wrEn && (paddr == REG_IRQSTAT))
      irqStat <= (irqStat & ~pwdata[IRQ_W-1:0]) | irqEvent;
    else
      irqStat <= irqStat | irqEvent;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(irqStat & irqMask);
  end

  // apb slave, one wait-free access phase
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        if (paddr == REG_CTRL)
          prdata <= ctrl;
        else if (paddr == REG_STATUS)
          prdata <= {28'h000_0000, state};
        else if (paddr == REG_PAGES)
          prdata <= pageCount;
        else if (paddr == REG_EXCCODE)
          prdata <= {16'h0000, excCode};
        else if (paddr == REG_IRQSTAT)
          prdata <= {28'h000_0000, irqStat};
        else if (paddr == REG_IRQMASK)
          prdata <= {28'h000_0000, irqMask};
        else if (paddr == REG_IMAGECRC)
          prdata <= imageCrc;
        else if (paddr == REG_TIMERS)
          prdata <= {trialCnt, restartCnt};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_exec(fumh_state_t st);
    msgOk && (msgType == TYPE_EXECUTE) && (state == st);
  endsequence

  property p_exec_zero;
    s_exec(ST_COMPLETE) and (reqRestartDelay == 16'h0000) |=> (state == ST_UPGRADE);
  endproperty
  a_exec_zero: assert property (p_exec_zero) else $error("zero delay not upgraded"); // [RULE5]

  property p_exec_delay;
    s_exec(ST_COMPLETE) and (reqRestartDelay != 16'h0000) |=> (state == ST_COUNTDOWN);
  endproperty
  a_exec_delay: assert property (p_exec_delay) else $error("delay not counted"); // [RULE4]

  property p_exec_reload;
    s_exec(ST_COUNTDOWN) |=> (restartCnt == $past(reqRestartDelay)) &&
                             (trialCnt == $past(reqTrialPeriod));
  endproperty
  a_exec_reload: assert property (p_exec_reload) else $error("timers not reloaded"); // [RULE6]

  property p_confirm;
    msgOk && (msgType == TYPE_CONFIRM) && (state == ST_UPGRADE)
      |=> (state == ST_IDLE) && dropOldImage;
  endproperty
  a_confirm: assert property (p_confirm) else $error("confirm not applied"); // [RULE7]

  property p_confirm_other;
    msgOk && (msgType == TYPE_CONFIRM) && (state != ST_UPGRADE)
      |=> $stable(state) && !dropOldImage;
  endproperty
  a_confirm_other: assert property (p_confirm_other) else $error("confirm acted"); // [RULE8]

  property p_abort;
    msgOk && (msgType == TYPE_ABORT) |=> (state == ST_IDLE);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not idle"); // [RULE10]

  property p_reply;
    msgOk && reqUnicast && (msgType != TYPE_REPORT) |=> ##1 rptValid && (rptHeader[7:4] == 4'h5);
  endproperty
  a_reply: assert property (p_reply) else $error("no state report"); // [RULE11]

  property p_fields;
    rptValid |-> (rptState[7:4] == $past(state)) && (rptState[3:0] == 4'h0) &&
                 (rptHasPages == (rptState[7:4] == ST_RECEIVING)) &&
                 (rptHasExc == (rptState[7:4] == ST_EXCEPTION)) && (rptCrc == $past(imageCrc));
  endproperty
  a_fields: assert property (p_fields) else $error("bad report fields"); // [RULE13]

  property p_trial_hold;
    (state == ST_COUNTDOWN) && !execTaken |=> $stable(trialCnt);
  endproperty
  a_trial_hold: assert property (p_trial_hold) else $error("trial counted early"); // [RULE3]

  property p_tick;
    tick && (state == ST_UPGRADE) && (trialCnt != 16'h0000) && !msgOk
      |=> (trialCnt == $past(trialCnt) - 16'h0001);
  endproperty
  a_tick: assert property (p_tick) else $error("trial not decremented"); // [RULE19]
endmodule : fumh_handler

// File: test/fumh_base_node.sv
// base node model sending control messages and counting node actions
`timescale 1ns/1ps
module fumh_base_node
  import fumh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rptValid,
  input  wire logic        dropOldImage,
  input  wire logic        eraseImage,
  input  wire logic        restartNow,
  output logic             reqValid,
  output logic             reqUnicast,
  output logic [7:0]       reqHeader,
  output logic [15:0]      reqRestartDelay,
  output logic [15:0]      reqTrialPeriod,
  output logic [31:0]      reqImageCrc
);
  int dropCnt    = 0;
  int eraseCnt   = 0;
  int restartCnt = 0;

  initial
  begin
    reqValid        = 1'b0;
    reqUnicast      = 1'b0;
    reqHeader       = 8'hFF;
    reqRestartDelay = 16'hFFFF;
    reqTrialPeriod  = 16'hFFFF;
    reqImageCrc     = 32'hFFFF_FFFF;
  end

  always @(posedge clk)
  begin
    if (dropOldImage === 1'b1) dropCnt <= dropCnt + 1;
    if (eraseImage === 1'b1) eraseCnt <= eraseCnt + 1;
    if (restartNow === 1'b1) restartCnt <= restartCnt + 1;
  end

  // one message, then watch a few cycles for the reply
  task send(input logic [3:0] ty, input logic [1:0] ver, input logic [15:0] dly,
            input logic [15:0] trl, input logic [31:0] crc, output logic got);
    int n;
    @(posedge clk);
    reqValid        <= 1'b1;
    reqUnicast      <= 1'b1;
    reqHeader       <= {ty, ver, 2'h0};
    reqRestartDelay <= dly;
    reqTrialPeriod  <= trl;
    reqImageCrc     <= crc;
    @(posedge clk);
    reqValid        <= 1'b0;
    reqUnicast      <= 1'b0;
    reqHeader       <= ~{ty, ver, 2'h0};
    reqRestartDelay <= ~dly;
    reqTrialPeriod  <= ~trl;
    reqImageCrc     <= ~crc;
    got = 1'b0;
    for (n = 0; n < 4 && !got; n++)
    begin
      @(posedge clk);
      if (rptValid === 1'b1) got = 1'b1;
    end
  endtask : send
endmodule : fumh_base_node

// File: test/firmware_update_msg_handler_tb.sv
// testbench of the firmware update message handler
`timescale 1ns/1ps
module firmware_update_msg_handler_tb;
  import fumh_pkg::*;
  localparam logic [31:0] CRC_OPEN = 32'hA5C3_1E77;
  localparam logic [31:0] CRC_ALT  = 32'h0F0F_0F0F;
  logic        clk, sysRst, psel, penable, pwrite, pready, pslverr, irq, got;
  logic        reqValid, reqUnicast, rptValid, rptHasPages, rptHasExc;
  logic        dropOldImage, eraseImage, restartNow;
  logic [7:0]  paddr, reqHeader, rptHeader, rptState;
  logic [15:0] reqRestartDelay, reqTrialPeriod, rptExcCode;
  logic [31:0] pwdata, prdata, reqImageCrc, rptCrc, rptPages, rd;
  int          miscompares = 0;
  int          comparisons = 0;
  int          c0;

  fumh_handler #(.TICK_CYCLES(10)) uut (.clk(clk), .sys_rst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reqValid(reqValid), .reqUnicast(reqUnicast),
    .reqHeader(reqHeader), .reqRestartDelay(reqRestartDelay),
    .reqTrialPeriod(reqTrialPeriod), .reqImageCrc(reqImageCrc), .rptValid(rptValid),
    .rptHeader(rptHeader), .rptState(rptState), .rptCrc(rptCrc),
    .rptHasPages(rptHasPages), .rptPages(rptPages), .rptHasExc(rptHasExc),
    .rptExcCode(rptExcCode), .dropOldImage(dropOldImage), .eraseImage(eraseImage),
    .restartNow(restartNow), .irq(irq));

  fumh_base_node node (.clk(clk), .rptValid(rptValid), .dropOldImage(dropOldImage),
    .eraseImage(eraseImage), .restartNow(restartNow), .reqValid(reqValid),
    .reqUnicast(reqUnicast), .reqHeader(reqHeader), .reqRestartDelay(reqRestartDelay),
    .reqTrialPeriod(reqTrialPeriod), .reqImageCrc(reqImageCrc));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1)
    begin
      miscompares++;
      end_sim();
    end
    rd      = prdata;
    got     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task report(input logic [3:0] ty, input logic [15:0] dly, input logic [15:0] trl,
              input logic [31:0] crc, input fumh_state_t st);
    node.send(ty, 2'h0, dly, trl, crc, got);
    check("reply", {31'h0, got}, 32'h1);
    check("header", {24'h0, rptHeader}, {24'h0, TYPE_REPORT, 4'h0});
    check("state", {24'h0, rptState}, {24'h0, st, 4'h0});
  endtask : report

  task wait_state(input fumh_state_t st);
    int n;
    for (n = 0; n < 100; n++)
    begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[3:0] === st) break;
    end
    check("state wait", rd, {28'h0, st});
    if (n == 100) end_sim();
  endtask : wait_state

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sysRst = 1'b1;
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", rd, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl", rd, CTRL_RESET);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", {31'h0, got}, 32'h1);
    $display("test reset done");

    report(TYPE_QUERY, 16'h0, 16'h0, CRC_ALT, ST_IDLE);
    check("no pages", {31'h0, rptHasPages}, 32'h0);
    node.send(TYPE_QUERY, 2'h1, 16'h0, 16'h0, CRC_ALT, got);
    check("bad version", {31'h0, got}, 32'h0);
    c0 = node.dropCnt;
    report(TYPE_CONFIRM, 16'h0, 16'h0, CRC_ALT, ST_IDLE);
    check("no drop", node.dropCnt, c0);
    $display("test idle done");

    report(TYPE_OPEN, 16'h0, 16'h0, CRC_OPEN, ST_RECEIVING);
    check("pages flag", {31'h0, rptHasPages}, 32'h1);
    apb(1'b1, REG_PAGES, 32'h7);
    report(TYPE_QUERY, 16'h0, 16'h0, CRC_ALT, ST_RECEIVING);
    check("crc echo", rptCrc, CRC_OPEN);
    check("pages", rptPages, 32'h7);
    report(TYPE_EXECUTE, 16'h0, 16'h5, CRC_ALT, ST_RECEIVING);
    $display("test receiving done");

    apb(1'b1, REG_SETSTATE, 32'h2);
    c0 = node.restartCnt;
    report(TYPE_EXECUTE, 16'h0, 16'h9, CRC_ALT, ST_UPGRADE);
    check("restart", node.restartCnt, c0 + 1);
    c0 = node.dropCnt;
    report(TYPE_CONFIRM, 16'h0, 16'h0, CRC_ALT, ST_IDLE);
    check("drop", node.dropCnt, c0 + 1);
    $display("test upgrade done");

    apb(1'b1, REG_SETSTATE, 32'h2);
    report(TYPE_EXECUTE, 16'h2, 16'h3, CRC_ALT, ST_COUNTDOWN);
    report(TYPE_EXECUTE, 16'h5, 16'h1, CRC_ALT, ST_COUNTDOWN);
    apb(1'b0, REG_TIMERS, 32'h0);
    check("trial reload", {16'h0, rd[31:16]}, 32'h1);
    repeat (25) @(posedge clk);
    apb(1'b0, REG_TIMERS, 32'h0);
    check("trial held", {16'h0, rd[31:16]}, 32'h1);
    wait_state(ST_UPGRADE);
    wait_state(ST_EXCEPTION);
    apb(1'b0, REG_EXCCODE, 32'h0);
    check("exc reg", rd, {16'h0, 1'b0, CAUSE_TRIAL, 8'h00});
    report(TYPE_QUERY, 16'h0, 16'h0, CRC_ALT, ST_EXCEPTION);
    check("exc flag", {31'h0, rptHasExc}, 32'h1);
    check("exc code", {16'h0, rptExcCode}, {16'h0, 1'b0, CAUSE_TRIAL, 8'h00});
    check("pages gone", {31'h0, rptHasPages}, 32'h0);
    $display("test timers done");

    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b1, REG_IRQSTAT, 32'hF);
    apb(1'b1, REG_IRQMASK, 32'h0);
    c0 = node.eraseCnt;
    report(TYPE_ABORT, 16'h0, 16'h0, CRC_ALT, ST_IDLE);
    check("erase", node.eraseCnt, c0 + 1);
    check("no exc", {31'h0, rptHasExc}, 32'h0);
    apb(1'b0, REG_IRQSTAT, 32'h0);
    check("irq status", rd, 32'h9);
    check("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, REG_IRQMASK, 32'h8);
    repeat (2) @(posedge clk);
    check("irq on", {31'h0, irq}, 32'h1);
    apb(1'b1, REG_IRQSTAT, 32'h8);
    repeat (2) @(posedge clk);
    check("irq off", {31'h0, irq}, 32'h0);
    $display("test abort done");

    apb(1'b0, REG_IMAGECRC, 32'h0);
    check("crc reg", rd, CRC_OPEN);
    apb(1'b1, REG_SETSTATE, 32'h5);
    apb(1'b1, REG_EXCCODE, 32'h8123);
    report(TYPE_QUERY, 16'h0, 16'h0, CRC_ALT, ST_EXCEPTION);
    check("exc forced", {16'h0, rptExcCode}, 32'h8123);
    apb(1'b1, REG_CTRL, 32'h0);
    c0 = node.eraseCnt;
    report(TYPE_ABORT, 16'h0, 16'h0, CRC_ALT, ST_IDLE);
    check("no erase", node.eraseCnt, c0);
    $display("test forced done");
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : firmware_update_msg_handler_tb
